//--- rtl/dcm_pkg.sv
// shared constants and carrier types for the dual counter mode control
package dcm_pkg;
    localparam int          ADDR_W            = 16;
    localparam int          DATA_W            = 16;
    localparam int          CNT_W             = 16;
    localparam int          NUM_GEN           = 4;
    localparam logic [15:0] START_CTL_OFS     = 16'h0137;
    localparam logic [15:0] MODE_OFS          = 16'h0138;
    localparam logic [15:0] CH_BASE_OFS       = 16'h0140;
    localparam logic [15:0] CH_STRIDE         = 16'h0010;
    localparam logic [15:0] GEN_STEP          = 16'h0002;
    localparam int          START_RUN_LSB     = 0;
    localparam int          START_STOPSEL_LSB = 2;
    localparam int          MODE_LOCKSTEP_BIT = 0;
    localparam int          MODE_FILL_LSB     = 1;
    localparam int          MODE_FILL_MSB     = 3;
    localparam int          MODE_BUF_LSB      = 4;
    localparam int          GEN_A             = 0;
    localparam int          GEN_B             = 1;
    localparam int          GEN_C             = 2;
    localparam int          GEN_D             = 3;
    localparam logic [7:0]  MODE_RESET        = 8'h0e;
    localparam logic [7:0]  START_CTL_RESET   = 8'h00;
    localparam logic [15:0] GEN_RESET         = 16'hffff;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic              wrStrobe;
        logic              rdStrobe;
    } dcm_bus_req_type;

    typedef struct packed {
        logic run;
        logic lockClear;
        logic bufA;
        logic bufB;
    } dcm_chan_ctl_type;
endpackage

//--- rtl/dcm_channel.sv
// one timer channel: counter, four general registers, compare and buffer transfer
`timescale 1ns/10ps
`default_nettype none
module dcm_channel #(
    parameter int CNT_W = dcm_pkg::CNT_W
) (
    input  wire logic                               clock,
    input  wire logic                               srst,
    input  wire dcm_pkg::dcm_chan_ctl_type          ctl,
    input  wire logic                               cntWrite,
    input  wire logic [dcm_pkg::NUM_GEN-1:0]        genWrite,
    input  wire logic [CNT_W-1:0]                   wrData,
    output var  logic [CNT_W-1:0]                   counter_reg,
    output var  logic [dcm_pkg::NUM_GEN-1:0][CNT_W-1:0] genReg_reg,
    output logic                                    matchA,
    output logic                                    matchB
);
    import dcm_pkg::*;

    if (CNT_W < 1 || CNT_W > DATA_W)
    begin : g_bad_width
        $error("dcm_channel: CNT_W must lie in 1..DATA_W");
    end

    assign matchA = ctl.run && (counter_reg == genReg_reg[GEN_A]);
    assign matchB = ctl.run && (counter_reg == genReg_reg[GEN_B]);

    // a match on A or the partner's clear restarts the count from zero
    always_ff @(posedge clock)
    begin
        if (srst)
            counter_reg <= '0;
        else if (cntWrite)
            counter_reg <= wrData;
        else if (ctl.run)
        begin
            if (matchA || ctl.lockClear)
                counter_reg <= '0;
            else
                counter_reg <= counter_reg + 1'b1;
        end
    end

    // software write beats the buffer transfer into the same register
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < NUM_GEN; i++)
        begin
            if (srst)
                genReg_reg[i] <= GEN_RESET[CNT_W-1:0];
            else if (genWrite[i])
                genReg_reg[i] <= wrData;
            else if (i == GEN_A && ctl.bufA && matchA)
                genReg_reg[i] <= genReg_reg[GEN_C];
            else if (i == GEN_B && ctl.bufB && matchB)
                genReg_reg[i] <= genReg_reg[GEN_D];
        end
    end
endmodule
`default_nettype wire

//--- rtl/dcm_mode_control.sv
// dual counter mode and start/stop control with register port
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module dcm_mode_control #(
    parameter int CNT_W = dcm_pkg::CNT_W
) (
    input  wire logic                     clock,
    input  wire logic                     srst,
    input  wire dcm_pkg::dcm_bus_req_type busReq,
    output var  logic [dcm_pkg::DATA_W-1:0] readData_reg,
    output var  logic [1:0]               countRun_reg,
    output var  logic [1:0]               matchAPulse_reg
);
    import dcm_pkg::*;

    if (CNT_W < 1 || CNT_W > DATA_W)
    begin : g_bad_width
        $error("dcm_mode_control: CNT_W must lie in 1..DATA_W");
    end

    logic [1:0]                        stopSel_reg;
    logic                              lockstep_reg;
    logic [3:0]                        bufSel_reg;
    logic [1:0][CNT_W-1:0]             counter;
    logic [1:0][NUM_GEN-1:0][CNT_W-1:0] genRegs;
    logic [1:0]                        matchA;
    logic [1:0]                        matchB;
    logic [1:0]                        cntHit;
    logic [1:0][NUM_GEN-1:0]           genHit;
    logic [1:0]                        cntWrite;
    logic                              startWr;
    logic                              modeWr;
    logic [DATA_W-1:0]                 readMux;

    assign startWr = busReq.wrStrobe && (busReq.addr == START_CTL_OFS);
    assign modeWr  = busReq.wrStrobe && (busReq.addr == MODE_OFS);

    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan
        localparam logic [15:0] CH_ADDR = CH_BASE_OFS + 16'(ch) * CH_STRIDE;
        dcm_chan_ctl_type ctl;

        assign cntHit[ch] = (busReq.addr == CH_ADDR);
        for (genvar g = 0; g < NUM_GEN; g++)
        begin : g_gen
            assign genHit[ch][g] = (busReq.addr == CH_ADDR + GEN_STEP * 16'(g + 1));
        end

        // in lockstep a counter write lands in both channels, and clears are shared
        assign cntWrite[ch] = busReq.wrStrobe && (cntHit[ch] || (lockstep_reg && cntHit[1 - ch]));
        assign ctl.run       = countRun_reg[ch];
        assign ctl.lockClear = lockstep_reg && matchA[1 - ch];
        assign ctl.bufA      = bufSel_reg[2 * ch];
        assign ctl.bufB      = bufSel_reg[2 * ch + 1];

        dcm_channel #(
            .CNT_W (CNT_W)
        ) u_channel (
            .clock       (clock),
            .srst        (srst),
            .ctl         (ctl),
            .cntWrite    (cntWrite[ch]),
            .genWrite    ({NUM_GEN{busReq.wrStrobe}} & genHit[ch]),
            .wrData      (busReq.wrData[CNT_W-1:0]),
            .counter_reg (counter[ch]),
            .genReg_reg  (genRegs[ch]),
            .matchA      (matchA[ch]),
            .matchB      (matchB[ch])
        );
    end

    // software write beats a same-cycle match so a restart is never lost
    always_ff @(posedge clock)
    begin
        for (int ch = 0; ch < 2; ch++)
        begin
            if (srst)
                countRun_reg[ch] <= START_CTL_RESET[START_RUN_LSB + ch];
            else if (startWr)
                countRun_reg[ch] <= busReq.wrData[START_RUN_LSB + ch];
            else if (!stopSel_reg[ch] && matchA[ch])
                countRun_reg[ch] <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            stopSel_reg <= START_CTL_RESET[START_STOPSEL_LSB +: 2];
        else if (startWr)
            stopSel_reg <= busReq.wrData[START_STOPSEL_LSB +: 2];
    end

    // unused mode bits are not stored; they read back as their reset ones
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            lockstep_reg <= MODE_RESET[MODE_LOCKSTEP_BIT];
            bufSel_reg   <= MODE_RESET[MODE_BUF_LSB +: 4];
        end
        else if (modeWr)
        begin
            lockstep_reg <= busReq.wrData[MODE_LOCKSTEP_BIT];
            bufSel_reg   <= busReq.wrData[MODE_BUF_LSB +: 4];
        end
    end

    always_comb
    begin
        readMux = '0;
        if (busReq.addr == START_CTL_OFS)
        begin
            readMux[START_RUN_LSB +: 2]     = countRun_reg;
            readMux[START_STOPSEL_LSB +: 2] = stopSel_reg;
        end
        else if (busReq.addr == MODE_OFS)
        begin
            readMux[MODE_LOCKSTEP_BIT]            = lockstep_reg;
            readMux[MODE_FILL_MSB:MODE_FILL_LSB]  = MODE_RESET[MODE_FILL_MSB:MODE_FILL_LSB];
            readMux[MODE_BUF_LSB +: 4]            = bufSel_reg;
        end
        for (int ch = 0; ch < 2; ch++)
        begin
            if (cntHit[ch])
                readMux = DATA_W'(counter[ch]);
            for (int g = 0; g < NUM_GEN; g++)
            begin
                if (genHit[ch][g])
                    readMux = DATA_W'(genRegs[ch][g]);
            end
        end
    end

    // unmapped addresses and idle cycles read as zero
    always_ff @(posedge clock)
    begin
        if (srst)
            readData_reg <= '0;
        else if (busReq.rdStrobe)
            readData_reg <= readMux;
        else
            readData_reg <= '0;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            matchAPulse_reg <= '0;
        else
            matchAPulse_reg <= matchA;
    end

    stop_on_match0_a: assert property (
        @(posedge clock) disable iff (srst)
        (matchA[0] && !stopSel_reg[0] && !startWr) |=> !countRun_reg[0] && matchAPulse_reg[0])
        else $error("channel 0 kept running after a stopping match");

    stop_on_match1_a: assert property (
        @(posedge clock) disable iff (srst)
        (matchA[1] && !stopSel_reg[1] && !startWr)
        |=> (!countRun_reg[1] && matchAPulse_reg[1]) ##1 (!countRun_reg[1] || $past(startWr)))
        else $error("channel 1 kept running after a stopping match");

    keep_on_match_a: assert property (
        @(posedge clock) disable iff (srst)
        (matchA[0] && stopSel_reg[0] && !startWr) |=> countRun_reg[0])
        else $error("channel 0 stopped on match with stop-select set");

    lockstep_write_a: assert property (
        @(posedge clock) disable iff (srst)
        (lockstep_reg && busReq.wrStrobe && cntHit[0]) |=> counter[0] == counter[1])
        else $error("lockstep write did not reach both counters");

    independent_write_a: assert property (
        @(posedge clock) disable iff (srst)
        (!lockstep_reg && cntWrite[0] && !countRun_reg[1] && !cntWrite[1]) |=> $stable(counter[1]))
        else $error("independent write disturbed channel 1");

    buffer_load_a: assert property (
        @(posedge clock) disable iff (srst)
        (bufSel_reg[0] && matchA[0] && !(busReq.wrStrobe && genHit[0][GEN_A]))
        |=> genRegs[0][GEN_A] == $past(genRegs[0][GEN_C]))
        else $error("buffer did not load channel 0 register A on match");

    plain_register_a: assert property (
        @(posedge clock) disable iff (srst)
        (!bufSel_reg[0] && matchA[0] && !(busReq.wrStrobe && genHit[0][GEN_A])) |=> $stable(genRegs[0][GEN_A]))
        else $error("plain register A changed on match");

    keep_on_match1_a: assert property (
        @(posedge clock) disable iff (srst)
        (matchA[1] && stopSel_reg[1] && !startWr) |=> countRun_reg[1])
        else $error("channel 1 stopped on match with stop-select set");

    run_write_a: assert property (
        @(posedge clock) disable iff (srst)
        startWr |=> countRun_reg == $past(busReq.wrData[START_RUN_LSB +: 2]))
        else $error("run bits did not follow a software write");

    lockstep_clear_a: assert property (
        @(posedge clock) disable iff (srst)
        (lockstep_reg && matchA[0] && countRun_reg[1] && !cntWrite[1]) |=> counter[1] == '0)
        else $error("lockstep match on channel 0 did not clear channel 1");

    buffer_load1_a: assert property (
        @(posedge clock) disable iff (srst)
        (bufSel_reg[2] && matchA[1] && !(busReq.wrStrobe && genHit[1][GEN_A]))
        |=> genRegs[1][GEN_A] == $past(genRegs[1][GEN_C]))
        else $error("buffer did not load channel 1 register A on match");

    plain_register1_a: assert property (
        @(posedge clock) disable iff (srst)
        (!bufSel_reg[2] && matchA[1] && !(busReq.wrStrobe && genHit[1][GEN_A])) |=> $stable(genRegs[1][GEN_A]))
        else $error("plain channel 1 register A changed on match");
endmodule
`default_nettype wire

//--- verif/dual_counter_mode_control_bench.sv
// self-checking bench for the dual counter mode control register port and timers
`timescale 1ns/10ps
`default_nettype none
module dual_counter_mode_control_bench;
    import dcm_pkg::*;
    logic                  clock;
    logic                  srst;
    dcm_bus_req_type       busReq;
    logic [DATA_W-1:0]     readData_reg;
    logic [1:0]            countRun_reg;
    logic [1:0]            matchAPulse_reg;
    int                    err_total;
    int                    n_compared;
    logic [15:0]           rdVal;

    dcm_mode_control i_dcm_mode_control (
        .clock           (clock),
        .srst            (srst),
        .busReq          (busReq),
        .readData_reg    (readData_reg),
        .countRun_reg    (countRun_reg),
        .matchAPulse_reg (matchAPulse_reg)
    );

    initial clock = 1'b0;
    always #12.5 clock = ~clock;

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got);
        n_compared++;
        if (got !== expv)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, expv, got);
        end
    endtask

    // one-cycle strobes; effect lands on the edge that ends the task
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clock);
        busReq <= '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
        @(posedge clock);
        busReq <= '0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a);
        @(posedge clock);
        busReq <= '{addr: a, wrData: 16'h0000, wrStrobe: 1'b0, rdStrobe: 1'b1};
        @(posedge clock);
        busReq <= '0;
        #1;
        rdVal = readData_reg;
    endtask

    // bounded wait so a missing match cannot hang the run
    task automatic wait_pulse(input int ch);
        for (int i = 0; i < 20; i++)
        begin
            @(posedge clock);
            #1;
            if (matchAPulse_reg[ch] === 1'b1)
                break;
        end
        chk("matchA pulse", 16'h0001, {15'h0000, matchAPulse_reg[ch]});
    endtask

    task automatic test_reset();
        rd(16'h0138); chk("mode reset", 16'h000e, rdVal);
        @(posedge clock);
        #1;
        chk("read data idle", 16'h0000, readData_reg);
        rd(16'h0137); chk("start reset", 16'h0000, rdVal);
        rd(16'h0142); chk("genA reset", 16'hffff, rdVal);
        rd(16'h0140); chk("counter reset", 16'h0000, rdVal);
        rd(16'h0100); chk("unmapped read", 16'h0000, rdVal);
        $display("test reset done");
    endtask

    task automatic test_ch0_stop();
        wr(16'h0142, 16'h0002);
        wr(16'h0137, 16'h0001);
        chk("run0 set", 16'h0001, {14'h0000, countRun_reg});
        wait_pulse(0);
        chk("run0 cleared", 16'h0000, {15'h0000, countRun_reg[0]});
        $display("test ch0 stop done");
    endtask

    task automatic test_ch1_stop();
        wr(16'h0152, 16'h0003);
        for (int sel = 1; sel >= 0; sel--)
        begin
            wr(16'h0150, 16'h0000);
            wr(16'h0137, sel ? 16'h000a : 16'h0002);
            wait_pulse(1);
            chk("run1 after match", 16'(sel), {15'h0000, countRun_reg[1]});
            if (sel == 1)
            begin
                wr(16'h0137, 16'h0008);
                chk("run1 soft stop", 16'h0000, {15'h0000, countRun_reg[1]});
            end
        end
        $display("test ch1 stop done");
    endtask

    task automatic test_lockstep();
        wr(16'h0138, 16'h0001);
        rd(16'h0138);
        chk("mode fill bits", 16'h000f, rdVal);
        wr(16'h0140, 16'h0005);
        rd(16'h0150);
        chk("lockstep counter1", 16'h0005, rdVal);
        wr(16'h0138, 16'h0000);
        wr(16'h0140, 16'h0007);
        rd(16'h0150);
        chk("independent counter1", 16'h0005, rdVal);
        // ch0 match at 2 must also clear ch1, which alone would run on to its own 3
        wr(16'h0138, 16'h0001);
        wr(16'h0140, 16'h0000);
        wr(16'h0137, 16'h000f);
        wait_pulse(0);
        wr(16'h0137, 16'h000c);
        rd(16'h0150);
        chk("lockstep shared clear", 16'h0002, rdVal);
        $display("test lockstep done");
    endtask

    task automatic test_buffer();
        wr(16'h0138, 16'h0050);
        wr(16'h0140, 16'h0000);
        wr(16'h0150, 16'h0000);
        wr(16'h0146, 16'h0004);
        wr(16'h0156, 16'h0006);
        wr(16'h0142, 16'h0002);
        rd(16'h0142);
        chk("genA before match", 16'h0002, rdVal);
        wr(16'h0137, 16'h000f);
        wait_pulse(0);
        wr(16'h0137, 16'h0000);
        rd(16'h0142);
        chk("genA from buffer", 16'h0004, rdVal);
        rd(16'h0152);
        chk("ch1 genA from buffer", 16'h0006, rdVal);
        $display("test buffer done");
    endtask

    initial
    begin
        err_total = 0;
        n_compared = 0;
        srst <= 1'b1;
        busReq <= '0;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        test_reset();
        test_ch0_stop();
        test_ch1_stop();
        test_lockstep();
        test_buffer();
        tally_and_finish();
    end

    // whole run is about a hundred cycles
    initial
    begin
        #(25 * 5000);
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
